// ==== include/crfi_consts.svh ====
// Purpose : Named constants for the remote frame and interrupt block
// Assumes : Included by the package and by every design module
// Notes   : Bit positions follow the global flag and global mask layouts
`ifndef CRFI_CONSTS_SVH
`define CRFI_CONSTS_SVH

// ----------
// Sizes
// ----------
`define CRFI_NMBX        32
`define CRFI_MBX_W       5
`define CRFI_SYS_W       7
`define CRFI_GREG_W      16

// ----------
// Global flag register fields (same layout on both lines)
// ----------
`define CRFI_GF_MBX      15
`define CRFI_GF_SYS_HI   14
`define CRFI_GF_SYS_LO   8
`define CRFI_GF_VEC_HI   4
`define CRFI_GF_VEC_LO   0

// ----------
// Global mask fields
// ----------
`define CRFI_GM_SYS_HI   14
`define CRFI_GM_SYS_LO   8
`define CRFI_GM_SIL      2
`define CRFI_GM_L1EN     1
`define CRFI_GM_L0EN     0

// ----------
// Reset and fill values
// ----------
`define CRFI_ZERO32      32'h0000_0000
`define CRFI_ZERO7       7'h00
`define CRFI_ZERO5       5'h00
`define CRFI_ZERO3       3'h0
`define CRFI_ZERO16      16'h0000
`define CRFI_ONE32       32'h0000_0001

`endif

// ==== include/crfi_pkg.sv ====
// Purpose : Types shared by the remote frame and interrupt block
// Assumes : crfi_consts.svh supplies all sizes
// Notes   : Kernel-facing events travel as packed structs
`include "crfi_consts.svh"

package crfi_pkg;

  // ----------
  // Kernel-facing carriers
  // ----------
  typedef struct packed {
    logic                   valid;      // Frame stored into a mailbox
    logic [`CRFI_MBX_W-1:0] mbx;        // Mailbox that took the frame
    logic                   overwrite;  // Unread message was overwritten
  } crfi_rx_evt_t;

  typedef struct packed {
    logic                   valid;      // Event pulse
    logic [`CRFI_MBX_W-1:0] mbx;        // Mailbox concerned
  } crfi_mbx_evt_t;

  typedef struct packed {
    logic                   valid;      // Request held until done
    logic [`CRFI_MBX_W-1:0] mbx;        // Mailbox to send
    logic                   remote;     // Send a remote request frame only
  } crfi_tx_req_t;

  typedef struct packed {
    logic write_denied;
    logic wakeup;
    logic bus_off;
    logic error_passive;
    logic warning;
  } crfi_sys_evt_t;

  typedef enum logic {
    CRFI_TX_IDLE,
    CRFI_TX_BUSY
  } crfi_tx_state_t;

endpackage : crfi_pkg

// ==== src/crfi_core.sv ====
// Summary of operation
// (R01) Software flags remote request in receive mailbox
// (R02) Receive mailbox with request sends remote frame
// (R03) Answer stored in mailbox sets receive pending
// (R04) Software keeps requesting identifiers unique across mailboxes
// (R05) Software sets auto answer before enabling mailbox
// (R06) Matching remote request sets transmit request automatically
// (R07) Finished auto answer sets transmit acknowledge
// (R08) Change data request blocks selected mailbox transmission
// (R09) Clearing change data request re-enables transmission
// (R10) Data change also works for normal transmit
// (R11) Two lines; write-1 clears global flags
// (R12) Per-mailbox level bit chooses interrupt line
// (R13) Per-mailbox mask; disabled mailbox never interrupts
// (R14) Global mask enables six system sources
// (R15) System line select moves system interrupts
// (R16) Line enable bits gate each interrupt line
// (R17) Global mask enables lost message interrupt
// (R18) Mailbox flag at bit 15, vector bits 4-0
// (R19) Mailbox cause makes 16-bit read negative
// (R20) CPU abort sets abort flag and record
// (R21) Overwrite sets lost flag, record and mailbox flag
// (R22) Pending and acknowledge bits clear on write-1
// (R23) Vector moves on; flag drops when none pending
//
// Purpose : Mailbox flags, transmit scheduling, remote frames and interrupts
// Assumes : Kernel, CPU and block share ref_clk_in; no synchronisers needed
// Notes   : Kernel filtering and frame storage live outside this block
`timescale 1ns/1ns
`include "crfi_consts.svh"

module crfi_core
  import crfi_pkg::*;
(
  input  wire logic                    ref_clk_in,               // System clock
  input  wire logic                    resetn_in,                // Async reset, active low
  // CPU configuration levels
  input  wire logic [`CRFI_NMBX-1:0]   mailbox_enable_in,        // Mailbox in use
  input  wire logic [`CRFI_NMBX-1:0]   mailbox_receive_in,       // 1 = receive mailbox
  input  wire logic [`CRFI_NMBX-1:0]   auto_answer_in,           // Auto answer mode
  input  wire logic                    change_data_request_in,   // Data update in progress
  input  wire logic [`CRFI_MBX_W-1:0]  mailbox_select_number_in, // Mailbox being updated
  input  wire logic [`CRFI_NMBX-1:0]   mailbox_line_select_in,   // 1 = line 1
  input  wire logic [`CRFI_NMBX-1:0]   mailbox_irq_enable_in,    // Per-mailbox irq mask
  input  wire logic [`CRFI_GREG_W-1:0] global_irq_enable_in,     // Global mask word
  // CPU write-1 pulses
  input  wire logic [`CRFI_NMBX-1:0]   transmit_request_set_in,  // Start transmission
  input  wire logic [`CRFI_NMBX-1:0]   abort_request_in,         // Abort pending send
  input  wire logic [`CRFI_NMBX-1:0]   receive_pending_clr_in,   // Clear pending bits
  input  wire logic [`CRFI_NMBX-1:0]   transmit_ack_clr_in,      // Clear acknowledge bits
  input  wire logic [`CRFI_NMBX-1:0]   abort_ack_clr_in,         // Clear abort records
  input  wire logic [`CRFI_NMBX-1:0]   lost_message_clr_in,      // Clear lost records
  input  wire logic [`CRFI_GREG_W-1:0] global_flags_clr0_in,     // Write-1 to line 0 flags
  input  wire logic [`CRFI_GREG_W-1:0] global_flags_clr1_in,     // Write-1 to line 1 flags
  // Protocol kernel side
  input  wire crfi_rx_evt_t            rx_evt_in,                // Frame stored
  input  wire crfi_mbx_evt_t           remote_rx_in,             // Remote request matched
  input  wire crfi_mbx_evt_t           tx_done_in,               // Transmission finished
  input  wire crfi_sys_evt_t           sys_evt_in,               // System event pulses
  output crfi_tx_req_t                 tx_req_out,               // Request to the kernel
  // Status
  output logic [`CRFI_NMBX-1:0]        transmit_request_out,     // Pending requests
  output logic [`CRFI_NMBX-1:0]        receive_pending_out,      // Receive pending bits
  output logic [`CRFI_NMBX-1:0]        transmit_acknowledge_out, // Acknowledge bits
  output logic [`CRFI_NMBX-1:0]        abort_acknowledge_out,    // Abort records
  output logic [`CRFI_NMBX-1:0]        lost_message_flags_out,   // Lost records
  output logic [`CRFI_GREG_W-1:0]      global_flags_line0_out,   // Line 0 flag word
  output logic [`CRFI_GREG_W-1:0]      global_flags_line1_out,   // Line 1 flag word
  output logic                         irq_line0_out,            // Interrupt line 0
  output logic                         irq_line1_out             // Interrupt line 1
);

  // ----------
  // Declarations
  // ----------
  crfi_tx_state_t          tx_state_ff;
  crfi_tx_state_t          nxt_tx_state;
  crfi_tx_req_t            tx_req_ff;
  logic [`CRFI_NMBX-1:0]   trs_set;
  logic [`CRFI_NMBX-1:0]   trs_clr;
  logic [`CRFI_NMBX-1:0]   busy_onehot;
  logic [`CRFI_NMBX-1:0]   cdr_block;
  logic [`CRFI_NMBX-1:0]   eligible;
  logic [`CRFI_NMBX-1:0]   done_onehot;
  logic [`CRFI_NMBX-1:0]   rx_onehot;
  logic [`CRFI_NMBX-1:0]   rrq_onehot;
  logic [`CRFI_NMBX-1:0]   rmp_set;
  logic [`CRFI_NMBX-1:0]   ta_set;
  logic [`CRFI_NMBX-1:0]   aa_set;
  logic [`CRFI_NMBX-1:0]   rml_set;
  logic [`CRFI_NMBX-1:0]   mb_pend;
  logic [`CRFI_NMBX-1:0]   mb_pend0;
  logic [`CRFI_NMBX-1:0]   mb_pend1;
  logic                    tx_found;
  logic [`CRFI_MBX_W-1:0]  tx_idx;
  logic                    found0;
  logic                    found1;
  logic [`CRFI_MBX_W-1:0]  vec0;
  logic [`CRFI_MBX_W-1:0]  vec1;
  logic [`CRFI_SYS_W-1:0]  sys_evt;
  logic [`CRFI_SYS_W-1:0]  sys_set0;
  logic [`CRFI_SYS_W-1:0]  sys_set1;
  logic [`CRFI_SYS_W-1:0]  sys_flags0;
  logic [`CRFI_SYS_W-1:0]  sys_flags1;
  logic [`CRFI_SYS_W-1:0]  sys_mask;
  logic                    system_line_select;
  logic [`CRFI_GREG_W-1:0] nxt_gflags0;
  logic [`CRFI_GREG_W-1:0] nxt_gflags1;
  logic                    nxt_irq0;
  logic                    nxt_irq1;
  logic [`CRFI_GREG_W-1:0] global_flags_line0_ff;
  logic [`CRFI_GREG_W-1:0] global_flags_line1_ff;
  logic                    irq_line0_ff;
  logic                    irq_line1_ff;

  // ----------
  // Event decode
  // ----------
  // Shifting a one into place keeps the mailbox decode to one expression
  assign done_onehot = tx_done_in.valid   ? (`CRFI_ONE32 << tx_done_in.mbx)   : `CRFI_ZERO32;
  assign rx_onehot   = rx_evt_in.valid    ? (`CRFI_ONE32 << rx_evt_in.mbx)    : `CRFI_ZERO32;
  assign rrq_onehot  = remote_rx_in.valid ? (`CRFI_ONE32 << remote_rx_in.mbx) : `CRFI_ZERO32;
  assign busy_onehot = (tx_state_ff == CRFI_TX_BUSY) ? (`CRFI_ONE32 << tx_req_ff.mbx)
                                                     : `CRFI_ZERO32;
  // The selected mailbox stays off the bus for the whole update window
  assign cdr_block   = change_data_request_in ? (`CRFI_ONE32 << mailbox_select_number_in)
                                              : `CRFI_ZERO32; // R08 R09 R10

  // ----------
  // Transmit request bits
  // ----------
  // Auto answer only for enabled transmit mailboxes
  assign trs_set = (transmit_request_set_in & mailbox_enable_in)
                 | (rrq_onehot & mailbox_enable_in & auto_answer_in
                    & ~mailbox_receive_in); // R06
  // The frame on the bus cannot be withdrawn; only waiting requests abort
  assign trs_clr = done_onehot | (abort_request_in & ~busy_onehot);

  crfi_flag_bank #(
    .WIDTH (`CRFI_NMBX)
  ) u_trs (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .set_in     (trs_set),
    .clr_in     (trs_clr),
    .flags_out  (transmit_request_out)
  );

  // ----------
  // Transmit scheduler
  // ----------
  assign eligible = transmit_request_out & mailbox_enable_in & ~cdr_block
                  & ~done_onehot; // R08

  crfi_pick u_tx_pick (
    .vec_in    (eligible),
    .found_out (tx_found),
    .idx_out   (tx_idx)
  );

  always_comb begin
    nxt_tx_state = tx_state_ff;
    case (tx_state_ff)
      CRFI_TX_IDLE: begin
        if (tx_found) begin
          nxt_tx_state = CRFI_TX_BUSY;
        end
      end
      CRFI_TX_BUSY: begin
        if (tx_done_in.valid && (tx_done_in.mbx == tx_req_ff.mbx)) begin
          nxt_tx_state = CRFI_TX_IDLE;
        end
      end
      default: begin
        nxt_tx_state = CRFI_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_state_ff <= CRFI_TX_IDLE;
    end else begin
      tx_state_ff <= nxt_tx_state;
    end
  end

  // Receive mailboxes send a remote request carrying their own identifier
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_req_ff <= '0;
    end else if (tx_state_ff == CRFI_TX_IDLE) begin
      tx_req_ff.valid  <= tx_found;
      tx_req_ff.mbx    <= tx_idx;
      tx_req_ff.remote <= mailbox_receive_in[tx_idx]; // R02
    end else if (nxt_tx_state == CRFI_TX_IDLE) begin
      tx_req_ff.valid <= 1'b0;
    end
  end

  assign tx_req_out = tx_req_ff;

  // ----------
  // Mailbox record flags
  // ----------
  // Answers to a remote request arrive as ordinary stored frames
  assign rmp_set = rx_onehot; // R03
  // A sent remote request is not a data transmission, so no acknowledge
  assign ta_set  = done_onehot & ~mailbox_receive_in; // R07
  assign aa_set  = abort_request_in & transmit_request_out & ~busy_onehot
                 & ~trs_set; // R20
  assign rml_set = (rx_evt_in.valid && rx_evt_in.overwrite) ? rx_onehot
                                                            : `CRFI_ZERO32; // R21

  crfi_flag_bank #(
    .WIDTH (`CRFI_NMBX)
  ) u_rmp (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .set_in     (rmp_set),
    .clr_in     (receive_pending_clr_in), // R22
    .flags_out  (receive_pending_out)
  );

  crfi_flag_bank #(
    .WIDTH (`CRFI_NMBX)
  ) u_ta (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .set_in     (ta_set),
    .clr_in     (transmit_ack_clr_in), // R22
    .flags_out  (transmit_acknowledge_out)
  );

  crfi_flag_bank #(
    .WIDTH (`CRFI_NMBX)
  ) u_aa (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .set_in     (aa_set),
    .clr_in     (abort_ack_clr_in),
    .flags_out  (abort_acknowledge_out)
  );

  crfi_flag_bank #(
    .WIDTH (`CRFI_NMBX)
  ) u_rml (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .set_in     (rml_set),
    .clr_in     (lost_message_clr_in),
    .flags_out  (lost_message_flags_out)
  );

  // ----------
  // Mailbox interrupt routing
  // ----------
  // Mailbox flag follows its sources, so clearing the cause releases it
  assign mb_pend  = (receive_pending_out | transmit_acknowledge_out)
                  & mailbox_enable_in & mailbox_irq_enable_in; // R13
  assign mb_pend1 = mb_pend & mailbox_line_select_in;  // R12
  assign mb_pend0 = mb_pend & ~mailbox_line_select_in; // R12

  crfi_pick u_pick0 (
    .vec_in    (mb_pend0),
    .found_out (found0),
    .idx_out   (vec0)
  );

  crfi_pick u_pick1 (
    .vec_in    (mb_pend1),
    .found_out (found1),
    .idx_out   (vec1)
  );

  // ----------
  // System interrupt flags
  // ----------
  // Order matches flag bits 14 down to 8
  assign sys_evt  = {|aa_set, sys_evt_in.write_denied, sys_evt_in.wakeup, |rml_set,
                     sys_evt_in.bus_off, sys_evt_in.error_passive,
                     sys_evt_in.warning}; // R20 R21
  assign system_line_select      = global_irq_enable_in[`CRFI_GM_SIL];
  assign sys_set0 = system_line_select ? `CRFI_ZERO7 : sys_evt; // R15
  assign sys_set1 = system_line_select ? sys_evt : `CRFI_ZERO7; // R15
  assign sys_mask = global_irq_enable_in[`CRFI_GM_SYS_HI:`CRFI_GM_SYS_LO]; // R14 R17

  crfi_flag_bank #(
    .WIDTH (`CRFI_SYS_W)
  ) u_sys0 (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .set_in     (sys_set0),
    .clr_in     (global_flags_clr0_in[`CRFI_GF_SYS_HI:`CRFI_GF_SYS_LO]), // R11
    .flags_out  (sys_flags0)
  );

  crfi_flag_bank #(
    .WIDTH (`CRFI_SYS_W)
  ) u_sys1 (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .set_in     (sys_set1),
    .clr_in     (global_flags_clr1_in[`CRFI_GF_SYS_HI:`CRFI_GF_SYS_LO]), // R11
    .flags_out  (sys_flags1)
  );

  // ----------
  // Global flag words and lines
  // ----------
  // Bit 15 on top makes a signed half-word read negative for mailbox causes
  assign nxt_gflags0 = {found0, sys_flags0, `CRFI_ZERO3, vec0}; // R18 R19 R23
  assign nxt_gflags1 = {found1, sys_flags1, `CRFI_ZERO3, vec1}; // R18 R19 R23

  assign nxt_irq0 = global_irq_enable_in[`CRFI_GM_L0EN]
                  & (found0 | (|(sys_flags0 & sys_mask))); // R11 R16
  assign nxt_irq1 = global_irq_enable_in[`CRFI_GM_L1EN]
                  & (found1 | (|(sys_flags1 & sys_mask))); // R11 R16

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      global_flags_line0_ff <= `CRFI_ZERO16;
      global_flags_line1_ff <= `CRFI_ZERO16;
    end else begin
      global_flags_line0_ff <= nxt_gflags0;
      global_flags_line1_ff <= nxt_gflags1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_line0_ff <= 1'b0;
      irq_line1_ff <= 1'b0;
    end else begin
      irq_line0_ff <= nxt_irq0;
      irq_line1_ff <= nxt_irq1;
    end
  end

  assign global_flags_line0_out = global_flags_line0_ff;
  assign global_flags_line1_out = global_flags_line1_ff;
  assign irq_line0_out          = irq_line0_ff;
  assign irq_line1_out          = irq_line1_ff;

endmodule : crfi_core

// ==== src/crfi_flag_bank.sv ====
// Purpose : Bank of sticky flags, set by hardware, cleared by write-1
// Assumes : set_in and clr_in are one-cycle pulses per bit
// Notes   : A set in the clearing cycle wins
`timescale 1ns/1ns
`include "crfi_consts.svh"

module crfi_flag_bank
  import crfi_pkg::*;
#(
  parameter int WIDTH = `CRFI_NMBX
) (
  input  wire logic             ref_clk_in,  // System clock
  input  wire logic             resetn_in,   // Async reset, active low
  input  wire logic [WIDTH-1:0] set_in,      // Per-bit set pulses
  input  wire logic [WIDTH-1:0] clr_in,      // Per-bit clear pulses
  output logic      [WIDTH-1:0] flags_out    // Flag flip-flops
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          flags_out[gi] <= 1'b0;
        end else begin
          flags_out[gi] <= set_in[gi] | (flags_out[gi] & ~clr_in[gi]);
        end
      end
    end
  endgenerate

endmodule : crfi_flag_bank

// ==== src/crfi_pick.sv ====
// Purpose : Finds the highest-numbered set bit of a mailbox vector
// Assumes : Purely combinational, read by registered logic only
// Notes   : Higher mailbox numbers win, as for transmit priority
`timescale 1ns/1ns
`include "crfi_consts.svh"

module crfi_pick
  import crfi_pkg::*;
(
  input  wire logic [`CRFI_NMBX-1:0]  vec_in,    // Candidate mailboxes
  output logic                        found_out, // Any bit set
  output logic      [`CRFI_MBX_W-1:0] idx_out    // Winning mailbox
);

  logic [`CRFI_MBX_W-1:0] idx_chain [`CRFI_NMBX:0];

  assign idx_chain[0] = `CRFI_ZERO5;

  genvar gi;
  generate
    for (gi = 0; gi < `CRFI_NMBX; gi++) begin : g_bit
      assign idx_chain[gi+1] = vec_in[gi] ? (`CRFI_MBX_W)'(gi) : idx_chain[gi];
    end
  endgenerate

  assign found_out = |vec_in;
  assign idx_out   = idx_chain[`CRFI_NMBX];

endmodule : crfi_pick

// ==== tb/crfi_core_asserts.sv ====
// Purpose : Port-level checks of crfi_core
// Assumes : Config levels stay steady around the events checked
// Notes   : Bound to every crfi_core instance
`timescale 1ns/1ns

module crfi_core_asserts
  import crfi_pkg::*;
(
  input wire logic                    ref_clk_in,               // Clock
  input wire logic                    resetn_in,                // Reset, active low
  input wire logic [`CRFI_NMBX-1:0]   mailbox_enable_in,        // In use
  input wire logic [`CRFI_NMBX-1:0]   mailbox_receive_in,       // Receive mailbox
  input wire logic [`CRFI_NMBX-1:0]   auto_answer_in,           // Auto answer
  input wire logic                    change_data_request_in,   // Update active
  input wire logic [`CRFI_MBX_W-1:0]  mailbox_select_number_in, // Updated mailbox
  input wire logic [`CRFI_NMBX-1:0]   mailbox_line_select_in,   // Line choice
  input wire logic [`CRFI_NMBX-1:0]   mailbox_irq_enable_in,    // Mailbox mask
  input wire logic [`CRFI_GREG_W-1:0] global_irq_enable_in,     // Global mask
  input wire crfi_rx_evt_t            rx_evt_in,                // Frame stored
  input wire crfi_mbx_evt_t           remote_rx_in,             // Remote request
  input wire crfi_mbx_evt_t           tx_done_in,               // Send finished
  input wire crfi_tx_req_t            tx_req_out,               // Kernel request
  input wire logic [`CRFI_NMBX-1:0]   transmit_request_out,     // Requests
  input wire logic [`CRFI_NMBX-1:0]   receive_pending_out,      // Pending
  input wire logic [`CRFI_NMBX-1:0]   transmit_acknowledge_out, // Acknowledge
  input wire logic [`CRFI_NMBX-1:0]   lost_message_flags_out,   // Lost
  input wire logic [`CRFI_GREG_W-1:0] global_flags_line0_out,   // Line 0 word
  input wire logic                    irq_line0_out             // Line 0
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  logic done_hit;
  assign done_hit = tx_done_in.valid && tx_done_in.mbx == tx_req_out.mbx;

  a_req_held_stable: assert property (tx_req_out.valid && !done_hit |=> $stable(tx_req_out))
    else $error("kernel request changed while outstanding");
  a_done_frees_req: assert property (tx_req_out.valid && done_hit |=> !tx_req_out.valid)
    else $error("request not dropped after done");
  a_remote_kind: assert property (tx_req_out.valid |->
    tx_req_out.remote == mailbox_receive_in[tx_req_out.mbx])
    else $error("frame kind does not follow direction");
  a_update_blocks_tx: assert property (!tx_req_out.valid && change_data_request_in |=>
    !(tx_req_out.valid && tx_req_out.mbx == $past(mailbox_select_number_in)))
    else $error("mailbox under update was sent");
  a_auto_sets_req: assert property (remote_rx_in.valid && mailbox_enable_in[remote_rx_in.mbx]
    && auto_answer_in[remote_rx_in.mbx] && !mailbox_receive_in[remote_rx_in.mbx]
    |=> transmit_request_out[$past(remote_rx_in.mbx)])
    else $error("auto answer did not raise request");
  a_done_sets_ack: assert property (tx_done_in.valid && !mailbox_receive_in[tx_done_in.mbx]
    |=> transmit_acknowledge_out[$past(tx_done_in.mbx)])
    else $error("acknowledge missing after send");
  a_rx_sets_pend: assert property (rx_evt_in.valid |=> receive_pending_out[$past(rx_evt_in.mbx)])
    else $error("pending missing after store");
  a_lost_on_over: assert property (rx_evt_in.valid && rx_evt_in.overwrite
    |=> lost_message_flags_out[$past(rx_evt_in.mbx)])
    else $error("lost record missing");
  a_line0_gated: assert property (irq_line0_out |-> $past(global_irq_enable_in[0]))
    else $error("disabled line asserted");
  a_mbx_flag_cause: assert property (global_flags_line0_out[15] |->
    $past(|((receive_pending_out | transmit_acknowledge_out) & ~mailbox_line_select_in
    & mailbox_irq_enable_in & mailbox_enable_in)))
    else $error("mailbox flag without enabled cause");
endmodule : crfi_core_asserts

bind crfi_core crfi_core_asserts crfi_core_asserts_inst (.*);

// ==== tb/crfi_core_tb.sv ====
// Purpose : Self-checking bench of crfi_core
// Assumes : Kernel model answers four cycles after a request
// Notes   : Bench inputs change on the falling edge; kernel model outputs on the rising edge
`timescale 1ns/1ns

module crfi_core_tb;
  import crfi_pkg::*;
  logic ref_clk_in = 1'b0, resetn_in = 1'b0, change_data_request_in = 1'b0, remote_kind;
  logic [31:0] mailbox_enable_in = 32'h0000_003F, mailbox_receive_in = 32'h0000_0020;
  logic [31:0] auto_answer_in = 32'h0000_0002, mailbox_line_select_in = 32'hFFFF_FFFE;
  logic [31:0] mailbox_irq_enable_in = 32'hFFFF_FFFF, transmit_request_set_in = '0;
  logic [31:0] abort_request_in = '0, receive_pending_clr_in = '0, transmit_ack_clr_in = '0;
  logic [31:0] abort_ack_clr_in = '0, lost_message_clr_in = '0, transmit_request_out;
  logic [31:0] receive_pending_out, transmit_acknowledge_out, abort_acknowledge_out;
  logic [31:0] lost_message_flags_out;
  logic [15:0] global_irq_enable_in = 16'h7F03, global_flags_clr0_in = '0;
  logic [15:0] global_flags_clr1_in = '0, global_flags_line0_out, global_flags_line1_out;
  logic [4:0]  mailbox_select_number_in = '0;
  logic        irq_line0_out, irq_line1_out;
  crfi_rx_evt_t  rx_evt_in, inj = '0;
  crfi_mbx_evt_t remote_rx_in = '0, tx_done_in;
  crfi_sys_evt_t sys_evt_in = '0;
  crfi_tx_req_t  tx_req_out;
  int mismatches = 0, total_checks = 0, cycles = 0;

  always #4 ref_clk_in = ~ref_clk_in;
  crfi_core crfi_core_inst (.*);
  crfi_kernel_model crfi_kernel_model_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .req_in(tx_req_out), .inj_in(inj), .done_out(tx_done_in), .rx_out(rx_evt_in),
    .remote_out(remote_kind));

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : wt
  always @(posedge ref_clk_in) if (++cycles > 5000) begin
    mismatches++;
    report_and_stop;
  end

  // ----------
  // Scenarios
  // ----------
  task t_normal_tx;
    change_data_request_in = 1'b1; mailbox_select_number_in = 5'h03;
    transmit_request_set_in = 32'h8; wt(1); transmit_request_set_in = '0; wt(12);
    chk(transmit_acknowledge_out, 32'h0);
    change_data_request_in = 1'b0; wt(12);
    chk(transmit_acknowledge_out, 32'h8);
    chk(remote_kind, 32'h0);
    chk(global_flags_line1_out, 32'h8003);
    chk(irq_line1_out, 32'h1);
    transmit_ack_clr_in = 32'h8; wt(1); transmit_ack_clr_in = '0; wt(3);
    chk({transmit_acknowledge_out, global_flags_line1_out, 15'h0, irq_line1_out}, 32'h0);
  endtask : t_normal_tx
  task t_remote;
    transmit_request_set_in = 32'h20; wt(1); transmit_request_set_in = '0; wt(16);
    chk(receive_pending_out, 32'h20);
    chk({remote_kind, transmit_acknowledge_out[30:0]}, 32'h8000_0000);
    receive_pending_clr_in = 32'h20; wt(1); receive_pending_clr_in = '0; wt(3);
    chk(receive_pending_out, 32'h0);
  endtask : t_remote
  task t_auto;
    change_data_request_in = 1'b1; mailbox_select_number_in = 5'h01;
    remote_rx_in = {1'b1, 5'h01}; wt(1); remote_rx_in = '0; wt(12);
    chk({transmit_request_out, transmit_acknowledge_out}, {32'h2, 32'h0});
    change_data_request_in = 1'b0; wt(12);
    chk(transmit_acknowledge_out, 32'h2);
    transmit_ack_clr_in = 32'h2; wt(1); transmit_ack_clr_in = '0; wt(3);
  endtask : t_auto
  task t_sys;
    sys_evt_in = 5'b00100; wt(1); sys_evt_in = '0; wt(3);
    chk({global_flags_line0_out, 15'h0, irq_line0_out}, 32'h0400_0001);
    global_flags_clr0_in = 16'h0400; wt(1); global_flags_clr0_in = '0; wt(3);
    chk({global_flags_line0_out, 15'h0, irq_line0_out}, 32'h0);
    global_irq_enable_in = 16'h7F06; sys_evt_in = 5'b00001; wt(1); sys_evt_in = '0; wt(3);
    chk({global_flags_line0_out, 15'h0, irq_line0_out}, 32'h0);
    chk({global_flags_line1_out, 15'h0, irq_line1_out}, 32'h0100_0001);
    global_flags_clr1_in = 16'h0100; global_irq_enable_in = 16'h7F03; wt(1);
    global_flags_clr1_in = '0;
    inj = {1'b1, 5'h00, 1'b1}; wt(1); inj = '0; wt(3);
    chk(lost_message_flags_out, 32'h1);
    chk({global_flags_line0_out, global_flags_line1_out}, 32'h8800_0000);
    change_data_request_in = 1'b1; mailbox_select_number_in = 5'h02;
    transmit_request_set_in = 32'h4; wt(1); transmit_request_set_in = '0; wt(2);
    abort_request_in = 32'h4; wt(1); abort_request_in = '0; wt(3);
    chk(abort_acknowledge_out, 32'h4);
    chk(global_flags_line0_out[14], 32'h1);
    abort_ack_clr_in = 32'h4; lost_message_clr_in = 32'h1; wt(1);
    abort_ack_clr_in = '0; lost_message_clr_in = '0; wt(1);
    chk({abort_acknowledge_out, lost_message_flags_out}, 64'h0);
    change_data_request_in = 1'b0;
  endtask : t_sys

  initial begin
    wt(10);
    resetn_in = 1'b1;
    wt(1);
    chk({global_flags_line0_out, global_flags_line1_out}, 32'h0);
    t_normal_tx();
    t_remote();
    t_auto();
    t_sys();
    report_and_stop();
  end
endmodule : crfi_core_tb

// ==== tb/crfi_kernel_model.sv ====
// Purpose : Far-side kernel and remote node model
// Assumes : One request outstanding at a time
// Notes   : A remote request is answered by a frame stored in the same mailbox
`timescale 1ns/1ns

module crfi_kernel_model
  import crfi_pkg::*;
(
  input  wire logic          ref_clk_in,  // Clock
  input  wire logic          resetn_in,   // Reset, active low
  input  wire crfi_tx_req_t  req_in,      // Request from the block
  input  wire crfi_rx_evt_t  inj_in,      // Extra stored frame from bench
  output crfi_mbx_evt_t      done_out,    // Send finished
  output crfi_rx_evt_t       rx_out,      // Frame stored
  output logic               remote_out   // Kind of the last frame sent
);
  logic [3:0] cnt_ff;
  logic       ans_ff;
  logic [4:0] ans_mbx_ff;

  assign rx_out = ans_ff ? {1'b1, ans_mbx_ff, 1'b0} : inj_in;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_ff <= 4'h0;
      ans_ff <= 1'b0;
      ans_mbx_ff <= 5'h00;
      remote_out <= 1'b0;
      done_out <= '0;
    end else begin
      // Released lines invert the mailbox every cycle, so every second cycle shows the last mailbox again
      done_out <= {1'b0, ~done_out.mbx};
      ans_ff <= done_out.valid && remote_out;
      ans_mbx_ff <= done_out.mbx;
      if (cnt_ff == 4'h0 && req_in.valid && !done_out.valid) begin
        cnt_ff <= 4'h4;
        remote_out <= req_in.remote;
      end else if (cnt_ff == 4'h1) begin
        cnt_ff <= 4'h0;
        done_out <= {1'b1, req_in.mbx};
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule : crfi_kernel_model
